// *** hspwm_ctrl.sv ***
// PWM master time base, special event, gating clock and generator control
//
// Function
// - Module enable bit runs time bases and PWM outputs (generator status works without it); resets to zero.
// - Idle-stop set halts master time base while CPU is idle.
// - Hardware sets special event status when an event is pending.
// - Special event enable gates the special event interrupt request.
// - Immediate period update loads active period at once, else at boundary.
// - Sync polarity set makes sync input and output active low.
// - Sync output enable drives time base sync pulse onto output pin.
// - External sync enable lets sync input restart the master time base.
// - Sync source code 000 selects the external sync pin; others reserved.
// - Postscaler emits one trigger per field-plus-one compare matches.
// - Prescaler divides by 1 to 64 for codes 000-110; 111 reserved.
// - Sixteen-bit master period, reset value 0xFFF8.
// - Special event compare value matched against master count.
// - Gating clock runs at prescaled rate over divider plus one.
// - Shared duty replaces generator duty when its select bit is set.
// - Generator status bits set by hardware, cleared by clearing enable.
// - Dead-time field selects positive, negative, off or compensation.
// - Compensation polarity picks shortened output only in compensation mode.
// - Center-align bit selects center or edge aligned operation.
// - External reset lets current limit reset an independent time base.
// - Immediate update loads duty, dead-time, phase values at once.
// - Center alignment needs independent time base, else ignored.
// - With independent time base, phase value is the local period.
`timescale 1ns/1ps
`include "hspwm_params.svh"

module hspwm_ctrl
  import hspwm_pkg::*;
#(
  parameter int NGEN = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // System status and pins
  input wire logic cpu_idle_in,
  input wire logic external_sync_input_in,
  output logic sync_output_pin_out,
  output logic special_event_trigger_out,
  output logic special_event_irq_out,
  output logic gating_clock_out,
  // Generator events and pins
  input wire logic [NGEN-1:0] current_limit_in,
  input wire logic [NGEN-1:0] compensation_input_in,
  input wire logic [NGEN-1:0] fault_event_in,
  input wire logic [NGEN-1:0] trigger_event_in,
  // Generator outputs
  output logic [NGEN-1:0] gen_irq_out,
  output logic [NGEN-1:0] high_side_output_out,
  output logic [NGEN-1:0] low_side_output_out,
  output logic [NGEN-1:0] center_align_active_out,
  output logic [NGEN-1:0][1:0] dead_time_mode_out,
  output logic [NGEN-1:0] shorten_high_out,
  output logic [NGEN-1:0] shorten_low_out,
  output logic [NGEN-1:0][13:0] dead_time_value_out,
  output logic [NGEN-1:0][13:0] alt_dead_time_value_out
);

  logic [15:0] tbctl_q, presc_q, per_buf_q, per_act_q, sevcmp_q, chop_q;
  logic [15:0] mdc_buf_q, mdc_act_q, mtb_q;
  logic [5:0] pre_cnt_q, pre_mask;
  logic [3:0] ps_cnt_q;
  logic [9:0] chop_cnt_q;
  logic sync_ff1_q, sync_ff2_q, sync_ff3_q;
  logic sev_stat_q, sev_trig_q, sev_irq_q, sync_out_q, gating_q;
  logic [15:0] rdata_q;
  logic [NGEN-1:0][15:0] gctl_q, duty_buf_q, phase_buf_q, dt_buf_q, adt_buf_q;
  logic en, run, tick, wrap, sync_rise, sync_restart, boundary, sev_match;
  logic wr_tb, wr_per, wr_mdc;

  assign en = tbctl_q[`HSPWM_TB_EN];
  assign run = en & ~(tbctl_q[`HSPWM_TB_IDLE] & cpu_idle_in);
  assign wr_tb = reg_wr_in & (reg_addr_in == `HSPWM_ADR_TBCTL);
  assign wr_per = reg_wr_in & (reg_addr_in == `HSPWM_ADR_PERIOD);
  assign wr_mdc = reg_wr_in & (reg_addr_in == `HSPWM_ADR_MDUTY);

  // prescale mask, reserved code divides by one
  always_comb begin
    if (presc_q[2:0] == `HSPWM_PRESC_RSVD) begin
      pre_mask = 6'h00;
    end else begin
      pre_mask = 6'((7'h01 << presc_q[2:0]) - 7'h01);
    end
  end
  assign tick = run & (pre_cnt_q == pre_mask);
  assign wrap = tick & (mtb_q >= per_act_q);
  assign sync_rise = (sync_ff2_q ^ tbctl_q[`HSPWM_TB_SPOL])
    & ~(sync_ff3_q ^ tbctl_q[`HSPWM_TB_SPOL]);
  assign sync_restart = en & tbctl_q[`HSPWM_TB_SYEN] & sync_rise
    & (tbctl_q[6:4] == `HSPWM_SRC_PIN);
  assign boundary = en & (sync_restart | wrap);
  assign sev_match = tick & (mtb_q == sevcmp_q);

  // Sync input synchroniser and edge history
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_ff1_q <= 1'b0;
      sync_ff2_q <= 1'b0;
      sync_ff3_q <= 1'b0;
    end else begin
      sync_ff1_q <= external_sync_input_in;
      sync_ff2_q <= sync_ff1_q;
      sync_ff3_q <= sync_ff2_q;
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tbctl_q <= `HSPWM_ZERO16;
      presc_q <= `HSPWM_ZERO16;
      sevcmp_q <= `HSPWM_ZERO16;
      chop_q <= `HSPWM_ZERO16;
    end else begin
      // writable fields; status keeps hardware value
      if (wr_tb) begin
        tbctl_q <= (reg_wdata_in & `HSPWM_TB_WMASK)
          | (tbctl_q & ~`HSPWM_TB_WMASK);
      end
      if (reg_wr_in && reg_addr_in == `HSPWM_ADR_PRESC) begin
        presc_q <= reg_wdata_in & `HSPWM_PRESC_MASK;
      end
      if (reg_wr_in && reg_addr_in == `HSPWM_ADR_SEVCMP) begin
        sevcmp_q <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `HSPWM_ADR_CHOP) begin
        chop_q <= reg_wdata_in & `HSPWM_CHOP_WMASK;
      end
    end
  end

  // Period buffer and active period
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      per_buf_q <= `HSPWM_PERIOD_RST;
      per_act_q <= `HSPWM_PERIOD_RST;
    end else begin
      if (wr_per) begin
        per_buf_q <= reg_wdata_in;
      end
      if (wr_per && tbctl_q[`HSPWM_TB_IMMEDIATE_PERIOD_UPDATE]) begin
        per_act_q <= reg_wdata_in;
      end else if (boundary) begin
        per_act_q <= per_buf_q;
      end
    end
  end

  // Shared duty buffer and active copy
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mdc_buf_q <= `HSPWM_ZERO16;
      mdc_act_q <= `HSPWM_ZERO16;
    end else begin
      if (wr_mdc) begin
        mdc_buf_q <= reg_wdata_in;
      end
      // shared duty follows generator 0 update mode
      if (wr_mdc && gctl_q[0][`HSPWM_G_IUE]) begin
        mdc_act_q <= reg_wdata_in;
      end else if (boundary) begin
        mdc_act_q <= mdc_buf_q;
      end
    end
  end

  // Prescaler and master time base counter
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_q <= 6'h00;
      mtb_q <= 16'h0000;
    end else begin
      if (!run || tick) begin
        pre_cnt_q <= en ? 6'h00 : pre_cnt_q & 6'h00;
      end else begin
        pre_cnt_q <= pre_cnt_q + 6'h01;
      end
      if (!en || sync_restart || wrap) begin
        mtb_q <= 16'h0000;
      end else if (tick) begin
        mtb_q <= mtb_q + 16'h0001;
      end
    end
  end

  // Special event postscaler, status and request
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ps_cnt_q <= 4'h0;
      sev_trig_q <= 1'b0;
      sev_stat_q <= 1'b0;
      sev_irq_q <= 1'b0;
    end else begin
      sev_trig_q <= 1'b0;
      if (!en) begin
        ps_cnt_q <= 4'h0;
      end else if (sev_match) begin
        if (ps_cnt_q == tbctl_q[3:0]) begin
          ps_cnt_q <= 4'h0;
          sev_trig_q <= 1'b1;
        end else begin
          ps_cnt_q <= ps_cnt_q + 4'h1;
        end
      end
      // set wins, hardware clears when enable is off
      if (sev_trig_q) begin
        sev_stat_q <= 1'b1;
      end else if (!tbctl_q[`HSPWM_TB_SEIE]) begin
        sev_stat_q <= 1'b0;
      end
      sev_irq_q <= (sev_stat_q | sev_trig_q) & tbctl_q[`HSPWM_TB_SEIE];
    end
  end

  // Sync output pin
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_out_q <= 1'b0;
    end else begin
      sync_out_q <= tbctl_q[`HSPWM_TB_SPOL]
        ^ (tbctl_q[`HSPWM_TB_SOEN] & boundary);
    end
  end

  // Gating clock generator
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      chop_cnt_q <= 10'h000;
      gating_q <= 1'b0;
    end else begin
      // divide prescaled ticks by divider plus one
      if (!chop_q[`HSPWM_CHOP_EN] || !en) begin
        chop_cnt_q <= 10'h000;
      end else if (tick) begin
        chop_cnt_q <= (chop_cnt_q >= chop_q[9:0]) ? 10'h000 : chop_cnt_q + 10'h001;
      end
      gating_q <= chop_q[`HSPWM_CHOP_EN] & en & (chop_cnt_q <= (chop_q[9:0] >> 1));
    end
  end

  // Per-generator control, buffers, time base and outputs
  for (genvar g = 0; g < NGEN; g++) begin : gen_pwm
    logic sel, cl_ff1_q, cl_ff2_q, cmp_ff1_q, cmp_ff2_q, dir_q;
    logic independent_time_base_select, cen, gb, local_wrap, xreset, immediate_update_enable;
    logic [15:0] lcnt_q, duty_act_q, phase_act_q, dt_act_q, adt_act_q;
    logic [15:0] cnt_now, duty_eff;
    logic [2:0] stat_d;

    assign sel = reg_wr_in & (reg_addr_in[7:4] == 4'(g + 1));
    assign independent_time_base_select = gctl_q[g][`HSPWM_G_ITB];
    assign immediate_update_enable = gctl_q[g][`HSPWM_G_IUE];
    // center mode only with independent base
    assign cen = gctl_q[g][`HSPWM_G_CAM] & independent_time_base_select;
    assign xreset = gctl_q[g][`HSPWM_G_EXTERNAL_RESET_CONTROL] & independent_time_base_select & cl_ff2_q;
    assign local_wrap = tick & (cen ? (dir_q & lcnt_q == 16'h0000)
      : (lcnt_q >= phase_act_q));
    assign gb = independent_time_base_select ? (en & (local_wrap | xreset)) : boundary;
    assign cnt_now = independent_time_base_select ? lcnt_q : mtb_q;
    assign duty_eff = gctl_q[g][`HSPWM_G_SHARED_DUTY_SELECT] ? mdc_act_q : duty_act_q;
    // status set while enabled, forced clear with enable off
    assign stat_d = gctl_q[g][12:10]
      & (gctl_q[g][15:13] | {fault_event_in[g], cl_ff2_q, trigger_event_in[g]});

    // Pin synchronisers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        cl_ff1_q <= 1'b0;
        cl_ff2_q <= 1'b0;
        cmp_ff1_q <= 1'b0;
        cmp_ff2_q <= 1'b0;
      end else begin
        cl_ff1_q <= current_limit_in[g];
        cl_ff2_q <= cl_ff1_q;
        cmp_ff1_q <= compensation_input_in[g];
        cmp_ff2_q <= cmp_ff1_q;
      end
    end

    // Control register and written buffers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        gctl_q[g] <= `HSPWM_ZERO16;
        duty_buf_q[g] <= `HSPWM_ZERO16;
        phase_buf_q[g] <= `HSPWM_ZERO16;
        dt_buf_q[g] <= `HSPWM_ZERO16;
        adt_buf_q[g] <= `HSPWM_ZERO16;
      end else begin
        if (sel && reg_addr_in[3:0] == `HSPWM_SUB_CTL) begin
          gctl_q[g][12:0] <= reg_wdata_in[12:0] & 13'(`HSPWM_G_WMASK);
          gctl_q[g][15:13] <= reg_wdata_in[12:10] & stat_d;
        end else begin
          gctl_q[g][15:13] <= stat_d;
        end
        if (sel && reg_addr_in[3:0] == `HSPWM_SUB_DUTY) duty_buf_q[g] <= reg_wdata_in;
        if (sel && reg_addr_in[3:0] == `HSPWM_SUB_PHASE) phase_buf_q[g] <= reg_wdata_in;
        if (sel && reg_addr_in[3:0] == `HSPWM_SUB_DT) begin
          dt_buf_q[g] <= reg_wdata_in & `HSPWM_DT_MASK;
        end
        if (sel && reg_addr_in[3:0] == `HSPWM_SUB_ALTDT) begin
          adt_buf_q[g] <= reg_wdata_in & `HSPWM_DT_MASK;
        end
      end
    end

    // active copies, immediate or at boundary
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        duty_act_q <= `HSPWM_ZERO16;
        phase_act_q <= `HSPWM_ZERO16;
        dt_act_q <= `HSPWM_ZERO16;
        adt_act_q <= `HSPWM_ZERO16;
      end else if (gb && !(sel && immediate_update_enable)) begin
        duty_act_q <= duty_buf_q[g];
        phase_act_q <= phase_buf_q[g];
        dt_act_q <= dt_buf_q[g];
        adt_act_q <= adt_buf_q[g];
      end else if (sel && immediate_update_enable) begin
        if (reg_addr_in[3:0] == `HSPWM_SUB_DUTY) duty_act_q <= reg_wdata_in;
        if (reg_addr_in[3:0] == `HSPWM_SUB_PHASE) phase_act_q <= reg_wdata_in;
        if (reg_addr_in[3:0] == `HSPWM_SUB_DT) dt_act_q <= reg_wdata_in & `HSPWM_DT_MASK;
        if (reg_addr_in[3:0] == `HSPWM_SUB_ALTDT) adt_act_q <= reg_wdata_in & `HSPWM_DT_MASK;
      end
    end

    // local time base, up or up-down
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        lcnt_q <= 16'h0000;
        dir_q <= 1'b0;
      end else if (!en || !independent_time_base_select || xreset || (local_wrap && !cen)) begin
        lcnt_q <= 16'h0000;
        dir_q <= 1'b0;
      end else if (tick) begin
        if (cen && !dir_q && lcnt_q >= phase_act_q) begin
          dir_q <= 1'b1;
          lcnt_q <= lcnt_q - 16'h0001;
        end else if (cen && dir_q && lcnt_q == 16'h0000) begin
          dir_q <= 1'b0;
          lcnt_q <= 16'h0001;
        end else begin
          lcnt_q <= dir_q ? lcnt_q - 16'h0001 : lcnt_q + 16'h0001;
        end
      end
    end

    // Generator outputs
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        high_side_output_out[g] <= 1'b0;
        low_side_output_out[g] <= 1'b0;
        center_align_active_out[g] <= 1'b0;
        dead_time_mode_out[g] <= 2'h0;
        shorten_high_out[g] <= 1'b0;
        shorten_low_out[g] <= 1'b0;
        dead_time_value_out[g] <= 14'h0000;
        alt_dead_time_value_out[g] <= 14'h0000;
        gen_irq_out[g] <= 1'b0;
      end else begin
        high_side_output_out[g] <= en & (cnt_now < duty_eff);
        low_side_output_out[g] <= en & ~(cnt_now < duty_eff);
        center_align_active_out[g] <= cen;
        dead_time_mode_out[g] <= gctl_q[g][7:6];
        shorten_high_out[g] <= (hspwm_dtc_t'(gctl_q[g][7:6]) == HSPWM_DT_COMP)
          & ~(cmp_ff2_q ^ gctl_q[g][`HSPWM_G_COMPENSATION_POLARITY]);
        shorten_low_out[g] <= (hspwm_dtc_t'(gctl_q[g][7:6]) == HSPWM_DT_COMP)
          & (cmp_ff2_q ^ gctl_q[g][`HSPWM_G_COMPENSATION_POLARITY]);
        dead_time_value_out[g] <= dt_act_q[13:0];
        alt_dead_time_value_out[g] <= adt_act_q[13:0];
        gen_irq_out[g] <= |stat_d;
      end
    end

    dut_gstat_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !gctl_q[g][`HSPWM_G_FLTIE] |=> !gctl_q[g][`HSPWM_G_FLTST])
      else $error("fault status survived cleared enable");
    center_needs_itb_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !independent_time_base_select |=> !center_align_active_out[g])
      else $error("center mode without independent base");
  end

  // Register read port, data valid the cycle after the strobe
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `HSPWM_ADR_TBCTL: rdata_q <= {tbctl_q[15:13], sev_stat_q, tbctl_q[11:0]} & 16'hBFFF;
        `HSPWM_ADR_PRESC: rdata_q <= presc_q;
        `HSPWM_ADR_PERIOD: rdata_q <= per_buf_q;
        `HSPWM_ADR_SEVCMP: rdata_q <= sevcmp_q;
        `HSPWM_ADR_CHOP: rdata_q <= chop_q;
        `HSPWM_ADR_MDUTY: rdata_q <= mdc_buf_q;
        `HSPWM_ADR_COUNT: rdata_q <= mtb_q;
        default: begin
          rdata_q <= 16'h0000;
          for (int i = 0; i < NGEN; i++) begin
            if (reg_addr_in[7:4] == 4'(i + 1)) begin
              case (reg_addr_in[3:0])
                `HSPWM_SUB_CTL: rdata_q <= gctl_q[i];
                `HSPWM_SUB_DUTY: rdata_q <= duty_buf_q[i];
                `HSPWM_SUB_PHASE: rdata_q <= phase_buf_q[i];
                `HSPWM_SUB_DT: rdata_q <= dt_buf_q[i];
                `HSPWM_SUB_ALTDT: rdata_q <= adt_buf_q[i];
                default: rdata_q <= 16'h0000;
              endcase
            end
          end
        end
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign sync_output_pin_out = sync_out_q;
  assign special_event_trigger_out = sev_trig_q;
  assign special_event_irq_out = sev_irq_q;
  assign gating_clock_out = gating_q;

  // Checks on the master time base and special event path
  sequence s_per_write_imm;
    wr_per && tbctl_q[`HSPWM_TB_IMMEDIATE_PERIOD_UPDATE];
  endsequence
  sequence s_idle_halt;
    en && tbctl_q[`HSPWM_TB_IDLE] && cpu_idle_in && !sync_restart;
  endsequence

  disabled_count_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !en |=> (mtb_q == 16'h0000) && !special_event_trigger_out)
    else $error("counter moved while disabled");
  idle_halt_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_idle_halt |=> $stable(mtb_q))
    else $error("time base ran in idle with halt set");
  per_imm_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_per_write_imm |=> per_act_q == $past(reg_wdata_in))
    else $error("period not loaded at once");
  per_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(wr_per && tbctl_q[`HSPWM_TB_IMMEDIATE_PERIOD_UPDATE]) && !boundary |=> $stable(per_act_q))
    else $error("active period changed off boundary");
  sev_irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    special_event_irq_out |-> $past(tbctl_q[`HSPWM_TB_SEIE]))
    else $error("special event request while disabled");
  sev_stat_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sev_trig_q |=> sev_stat_q)
    else $error("status missed a trigger");
  post_one_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sev_match && tbctl_q[3:0] == 4'h0 && en |=> special_event_trigger_out)
    else $error("1:1 postscale missed a match");
  sync_out_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !tbctl_q[`HSPWM_TB_SOEN] |=> sync_output_pin_out == $past(tbctl_q[`HSPWM_TB_SPOL]))
    else $error("sync output active while disabled");
  wrap_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wrap |=> mtb_q == 16'h0000 ##1 (mtb_q <= 16'h0001))
    else $error("counter failed to wrap");

endmodule

// *** hspwm_ctrl_bench.sv ***
// Self-checking bench for the PWM control block
`timescale 1ns/1ps
`include "hspwm_params.svh"
module hspwm_ctrl_bench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic idle = 1'b0;
  logic sync_run = 1'b0;
  logic pol = 1'b0;
  logic gprev;
  logic [2:0] comp = 3'h0;
  logic [2:0] flt = 3'h0;
  logic [2:0] clim = 3'h0;
  logic [15:0] rdata;
  logic sync_pin, sync_o, trig, irq, gclk;
  logic [2:0] girq, ca, shh, shl, hs;
  logic [2:0][1:0] dtm;
  int error_cnt = 0;
  int compares = 0;
  int t, s, q, g, h;
  hspwm_sync_src u_src (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .run_in(sync_run),
    .active_low_in(1'b0), .gap_in(16'h0064), .sync_out(sync_pin));
  hspwm_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .cpu_idle_in(idle), .external_sync_input_in(sync_pin), .sync_output_pin_out(sync_o),
    .special_event_trigger_out(trig), .special_event_irq_out(irq), .gating_clock_out(gclk),
    .current_limit_in(clim), .compensation_input_in(comp), .fault_event_in(flt),
    .trigger_event_in(3'h0), .gen_irq_out(girq), .high_side_output_out(hs),
    .low_side_output_out(), .center_align_active_out(ca), .dead_time_mode_out(dtm),
    .shorten_high_out(shh), .shorten_low_out(shl), .dead_time_value_out(),
    .alt_dead_time_value_out());
  // System clock
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task report_and_stop();
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Counts triggers, sync pulses, irq cycles, gating rises and high-side cycles
  task cnt_win(input int n);
    t = 0;
    s = 0;
    q = 0;
    g = 0;
    h = 0;
    gprev = gclk;
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
      t += int'(trig === 1'b1);
      s += int'(sync_o !== pol);
      q += int'(irq === 1'b1);
      g += int'(gclk === 1'b1 && gprev === 1'b0);
      h += int'(hs[0] === 1'b1);
      gprev = gclk;
    end
  endtask
  // Period 2, compare 1: one match per master cycle
  task run_cfg(input int p, input int ps, input bit se, pl, so, il);
    int win;
    win = 12 * ((p == 7) ? 1 : (1 << p)) * (ps + 1);
    wr(`HSPWM_ADR_TBCTL, 16'h0400);
    idle <= il;
    pol = pl;
    wr(`HSPWM_ADR_PRESC, 16'(p));
    wr(`HSPWM_ADR_PERIOD, 16'h0002);
    wr(`HSPWM_ADR_SEVCMP, 16'h0001);
    wr(`HSPWM_ADR_TBCTL, {1'b1, 1'b0, il, 1'b0, se, 1'b1, pl, so, 4'h0, 4'(ps)});
    cnt_win(win);
    cnt_win(win);
    chk(16'(t), il ? 16'h0000 : 16'h0004);
    chk(16'(s), (so && !il) ? 16'(4 * (ps + 1)) : 16'h0000);
    chk(16'(q > 0), 16'(se && !il));
  endtask
  task gen(input logic [15:0] ctl, input logic c, input logic [4:0] exp);
    wr(8'h10, ctl);
    comp <= {3{c}};
    repeat (6) @(posedge clk_sys_in);
    #1 chk({11'h000, ca[0], dtm[0], shh[0], shl[0]}, {11'h000, exp});
  endtask
  // Watchdog
  initial begin
    #400us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(`HSPWM_ADR_PERIOD, 16'hFFF8);
    rd(`HSPWM_ADR_TBCTL, 16'h0000);
    rd(`HSPWM_ADR_PRESC, 16'h0000);
    rd(8'h7F, 16'h0000);
    wr(`HSPWM_ADR_TBCTL, 16'h5000);
    rd(`HSPWM_ADR_TBCTL, 16'h0000);
    run_cfg(0, 0, 1, 0, 1, 0);
    run_cfg(1, 1, 0, 1, 1, 0);
    run_cfg(2, 15, 1, 0, 0, 0);
    run_cfg(6, 0, 0, 1, 1, 0);
    run_cfg(7, 1, 1, 0, 1, 0);
    run_cfg(0, 3, 1, 0, 1, 1);
    rd(`HSPWM_ADR_TBCTL, 16'hAD03);
    @(posedge clk_sys_in);
    idle <= 1'b0;
    pol = 1'b0;
    sync_run <= 1'b1;
    wr(`HSPWM_ADR_TBCTL, 16'h0400);
    // Period above the 100-cycle sync spacing
    wr(`HSPWM_ADR_PERIOD, 16'h00C8);
    wr(`HSPWM_ADR_TBCTL, 16'h8580);
    cnt_win(1000);
    chk(16'(s > 8 && s < 12), 16'h0001);
    wr(`HSPWM_ADR_TBCTL, 16'h0400);
    wr(`HSPWM_ADR_TBCTL, 16'h8500);
    cnt_win(1000);
    chk(16'(s > 3 && s < 6), 16'h0001);
    // Reserved sync source code must not restart the base
    wr(`HSPWM_ADR_TBCTL, 16'h0400);
    wr(`HSPWM_ADR_TBCTL, 16'h8590);
    cnt_win(1000);
    chk(16'(s > 3 && s < 6), 16'h0001);
    wr(`HSPWM_ADR_CHOP, 16'h8003);
    cnt_win(40);
    chk(16'(g), 16'h000A);
    wr(`HSPWM_ADR_TBCTL, 16'h0000);
    gen(16'h00E0, 1'b0, 5'h0D);
    gen(16'h00E0, 1'b1, 5'h0E);
    gen(16'h00C0, 1'b0, 5'h0E);
    gen(16'h00A4, 1'b1, 5'h08);
    gen(16'h0204, 1'b1, 5'h10);
    gen(16'h0064, 1'b1, 5'h04);
    wr(8'h10, 16'h1000);
    flt <= 3'h1;
    @(posedge clk_sys_in);
    flt <= 3'h0;
    repeat (3) @(posedge clk_sys_in);
    rd(8'h10, 16'h9000);
    chk(16'(girq[0]), 16'h0001);
    wr(8'h10, 16'h0000);
    rd(8'h10, 16'h0000);
    // Generator 0 on its own base with shared duty and immediate updates
    wr(8'h10, 16'h0303);
    wr(8'h12, 16'h0003);
    wr(`HSPWM_ADR_MDUTY, 16'h0002);
    wr(`HSPWM_ADR_TBCTL, 16'h8000);
    wr(`HSPWM_ADR_PERIOD, 16'h0004);
    cnt_win(40);
    chk(16'(h), 16'h0014);
    @(posedge clk_sys_in);
    clim <= 3'h1;
    repeat (4) @(posedge clk_sys_in);
    cnt_win(20);
    chk(16'(h), 16'h0014);
    report_and_stop();
  end
endmodule

// *** hspwm_params.svh ***
// Register map, field positions and reset values of the PWM control block
`ifndef HSPWM_PARAMS_SVH
`define HSPWM_PARAMS_SVH
// Register offsets (word index on the register port)
`define HSPWM_ADR_TBCTL 8'h00
`define HSPWM_ADR_PRESC 8'h01
`define HSPWM_ADR_PERIOD 8'h02
`define HSPWM_ADR_SEVCMP 8'h03
`define HSPWM_ADR_CHOP 8'h04
`define HSPWM_ADR_MDUTY 8'h05
`define HSPWM_ADR_COUNT 8'h06
// Generator blocks sit at 0x10 * (index + 1); low nibble selects the register
`define HSPWM_SUB_CTL 4'h0
`define HSPWM_SUB_DUTY 4'h1
`define HSPWM_SUB_PHASE 4'h2
`define HSPWM_SUB_DT 4'h3
`define HSPWM_SUB_ALTDT 4'h4
// Time base control fields
`define HSPWM_TB_EN 15
`define HSPWM_TB_IDLE 13
`define HSPWM_TB_SEST 12
`define HSPWM_TB_SEIE 11
`define HSPWM_TB_IMMEDIATE_PERIOD_UPDATE 10
`define HSPWM_TB_SPOL 9
`define HSPWM_TB_SOEN 8
`define HSPWM_TB_SYEN 7
`define HSPWM_TB_SRC_LSB 4
`define HSPWM_TB_PS_LSB 0
`define HSPWM_TB_WMASK 16'hAFFF
`define HSPWM_SRC_PIN 3'h0
// Prescaler and period
`define HSPWM_PRESC_RSVD 3'h7
`define HSPWM_PRESC_MASK 16'h0007
`define HSPWM_PERIOD_RST 16'hFFF8
// Gating clock fields
`define HSPWM_CHOP_EN 15
`define HSPWM_CHOP_WMASK 16'h83FF
// Generator control fields
`define HSPWM_G_FLTST 15
`define HSPWM_G_CLST 14
`define HSPWM_G_TRGST 13
`define HSPWM_G_FLTIE 12
`define HSPWM_G_CLIE 11
`define HSPWM_G_TRGIE 10
`define HSPWM_G_ITB 9
`define HSPWM_G_SHARED_DUTY_SELECT 8
`define HSPWM_G_DTC_LSB 6
`define HSPWM_G_COMPENSATION_POLARITY 5
`define HSPWM_G_CAM 2
`define HSPWM_G_EXTERNAL_RESET_CONTROL 1
`define HSPWM_G_IUE 0
`define HSPWM_G_WMASK 16'h1FE7
`define HSPWM_DT_MASK 16'h3FFF
`define HSPWM_ZERO16 16'h0000
`endif

// *** hspwm_pkg.sv ***
// Types shared by the PWM control block
package hspwm_pkg;
  typedef enum logic [1:0] {
    HSPWM_DT_POS = 2'h0,
    HSPWM_DT_NEG = 2'h1,
    HSPWM_DT_OFF = 2'h2,
    HSPWM_DT_COMP = 2'h3
  } hspwm_dtc_t;
endpackage

// *** hspwm_sync_src.sv ***
// Far-side model: an external source of time base sync pulses
`timescale 1ns/1ps
module hspwm_sync_src (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control from the bench
  input wire logic run_in,
  input wire logic active_low_in,
  input wire logic [15:0] gap_in,
  // Sync pin
  output logic sync_out
);
  logic [15:0] cnt_q;
  // Gap counter, idle while stopped
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 16'h0000;
    end else if (!run_in || cnt_q == gap_in - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= active_low_in ^ (run_in && cnt_q < 16'h0004);
    end
  end
endmodule
